// >>> hdl/reclock_ctrl.sv
// control, indicator and output steering logic of the reclocker
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module reclock_ctrl
  import reclock_ctrl_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [3:0]  serial_input_i,
  input  wire logic        recovered_clk_i,
  input  wire logic        pll_lock_i,
  input  wire logic        signal_detect_i,
  input  wire logic [1:0]  rate_detect_i,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             primary_serial_output_o,
  output logic             second_serial_output_o,
  output logic             pll_acquired_flag_o,
  output logic             rate_class_indicator_o,
  output logic             crystal_drive_out_o
);

  // pin synchroniser, three stages per bit
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync3_r;
  logic [SYNC_W-1:0] flt_r;

  // control register fields
  logic [7:0]        ctrl_r;
  logic              silence_n;
  logic              skip_force;
  logic              clk_select;
  logic              enable;
  logic [1:0]        speed_code;
  logic [1:0]        channel;

  // filtered pin values
  logic [3:0]        data_in;
  logic              rec_clk;
  logic              pll_lock;
  logic              sig_det;
  logic [1:0]        det_rate;

  // reference tick generation
  logic [ACC_W-1:0]  acc_r;
  logic [ACC_W-1:0]  acc_sum;
  logic              ref_lvl_r;
  logic              ref_tick;

  // lock, rate and data path
  logic              rate_ok;
  logic              lock_nxt;
  logic              skip_active;
  logic              rec_prev_r;
  logic              retime_r;
  logic              sel_data;
  logic              data_nxt;
  logic              second_nxt;
  logic              mute_all;
  logic              lock_clr;
  logic              class_nxt;
  logic              rec_rise;

  // bus side
  logic [31:0]       awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              do_write;
  logic [31:0]       rdata_nxt;
  logic [1:0]        rresp_nxt;
  logic              wr_ctrl_hit;
  logic              wr_map_hit;
  logic              rd_ctrl_hit;
  logic              rd_status_hit;

  assign pins = {rate_detect_i, signal_detect_i, pll_lock_i,
                 recovered_clk_i, serial_input_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      // a change is taken only once stages two and three agree
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          flt_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pins[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            flt_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  assign data_in = flt_r[3:0];
  assign rec_clk = flt_r[4];
  assign pll_lock = flt_r[5];
  assign sig_det = flt_r[6];
  assign det_rate = flt_r[8:7];

  assign silence_n = ctrl_r[SILENCE_N_BIT];
  assign skip_force = ctrl_r[SKIP_FORCE_BIT];
  assign clk_select = ctrl_r[CLK_SELECT_BIT];
  assign enable = ctrl_r[ENABLE_BIT];
  assign speed_code = ctrl_r[SPEED_LSB +: 2];
  assign channel = ctrl_r[CHANNEL_LSB +: 2];

  // reference divider; free running regardless of enable
  assign acc_sum = acc_r + ACC_STEP;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_r <= '0;
      ref_lvl_r <= 1'b0;
    end else if (acc_sum >= ACC_WRAP) begin
      acc_r <= acc_sum - ACC_WRAP;
      ref_lvl_r <= ~ref_lvl_r;
    end else begin
      acc_r <= acc_sum;
    end
  end

  assign ref_tick = (acc_sum >= ACC_WRAP) && !ref_lvl_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      crystal_drive_out_o <= 1'b0;
    end else begin
      crystal_drive_out_o <= ref_lvl_r;
    end
  end

  // fixed speed codes accept only their own class; code 11 behaves as auto
  always_comb begin
    case (speed_code)
      SPEED_SD: rate_ok = (det_rate == DET_SD);
      SPEED_HD: rate_ok = (det_rate == DET_HD);
      SPEED_AUTO: rate_ok = (det_rate == DET_SD) || (det_rate == DET_HD);
      default: rate_ok = (det_rate == DET_SD) || (det_rate == DET_HD);
    endcase
  end

  assign lock_nxt = enable && !skip_force && sig_det && pll_lock && rate_ok;

  // force and power-down drop both indicators at once rather than at the next tick
  assign lock_clr = !enable || skip_force;

  // flag and class change only on the reference tick or at once on lock_clr, so no glitches
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pll_acquired_flag_o <= 1'b0;
    end else if (lock_clr) begin
      pll_acquired_flag_o <= 1'b0;
    end else if (ref_tick) begin
      pll_acquired_flag_o <= lock_nxt;
    end
  end

  // class follows the flag one tick late; ignore it around changes
  assign class_nxt = pll_acquired_flag_o && (det_rate == DET_SD);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate_class_indicator_o <= 1'b0;
    end else if (lock_clr) begin
      rate_class_indicator_o <= 1'b0;
    end else if (ref_tick) begin
      rate_class_indicator_o <= class_nxt;
    end
  end

  assign skip_active = skip_force || !pll_acquired_flag_o;

  assign sel_data = data_in[channel];

  // retime on the recovered clock rising edge
  assign rec_rise = rec_clk && !rec_prev_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rec_prev_r <= 1'b0;
    end else begin
      rec_prev_r <= rec_clk;
    end
  end

  // capture sleeps while disabled; the edge tracker keeps running so no stale edge on wake
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      retime_r <= 1'b0;
    end else if (enable && rec_rise) begin
      retime_r <= sel_data;
    end
  end

  assign mute_all = !silence_n || !enable;

  always_comb begin
    if (mute_all) begin
      data_nxt = 1'b0;
    end else if (skip_active) begin
      data_nxt = sel_data;
    end else begin
      data_nxt = retime_r;
    end
  end

  always_comb begin
    if (mute_all) begin
      second_nxt = 1'b0;
    end else if (clk_select && skip_active) begin
      second_nxt = 1'b0;
    end else if (clk_select) begin
      second_nxt = rec_clk;
    end else begin
      second_nxt = data_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      primary_serial_output_o <= 1'b0;
      second_serial_output_o <= 1'b0;
    end else begin
      primary_serial_output_o <= data_nxt;
      second_serial_output_o <= second_nxt;
    end
  end

  // write channel: address and data taken in either order
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // decode on the word index; the low two address bits are ignored
  assign wr_ctrl_hit = (awaddr_r[31:2] == CTRL_OFFSET[31:2]);
  assign wr_map_hit = wr_ctrl_hit || (awaddr_r[31:2] == STATUS_OFFSET[31:2]);
  assign rd_ctrl_hit = (s_axi_araddr[31:2] == CTRL_OFFSET[31:2]);
  assign rd_status_hit = (s_axi_araddr[31:2] == STATUS_OFFSET[31:2]);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready <= 1'b1;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_wready <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_map_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reset value gives the pulled pin defaults
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (do_write && wr_ctrl_hit && wstrb_r[0]) begin
      ctrl_r <= wdata_r[7:0];
    end
  end

  // read channel: one word answered the cycle after the address is taken
  always_comb begin
    rdata_nxt = '0;
    rresp_nxt = RESP_OKAY;
    if (rd_ctrl_hit) begin
      rdata_nxt[7:0] = ctrl_r;
    end else if (rd_status_hit) begin
      rdata_nxt[ST_LOCK_BIT] = pll_acquired_flag_o;
      rdata_nxt[ST_RATE_BIT] = rate_class_indicator_o;
      rdata_nxt[ST_SKIP_BIT] = skip_active;
      rdata_nxt[ST_PLL_BIT] = pll_lock;
      rdata_nxt[ST_DET_LSB +: 2] = det_rate;
    end else begin
      rresp_nxt = RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rresp_nxt;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // reclock_ctrl

// >>> hdl/reclock_ctrl_pkg.sv
// constants and register map for the reclocker control logic
package reclock_ctrl_pkg;
  localparam int SYS_FREQ_KHZ = 125000;
  localparam int REF_FREQ_KHZ = 27000;
  localparam int REF_PERIOD_NS = 37;
  localparam int ACC_W = 18;
  // half-period toggle, so the step is twice the reference rate
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(2 * REF_FREQ_KHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(SYS_FREQ_KHZ);

  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

  localparam int SILENCE_N_BIT = 0;
  localparam int SKIP_FORCE_BIT = 1;
  localparam int CLK_SELECT_BIT = 2;
  localparam int ENABLE_BIT = 3;
  localparam int SPEED_LSB = 4;
  localparam int CHANNEL_LSB = 6;
  localparam logic [7:0] CTRL_RESET = 8'h09;

  localparam int ST_LOCK_BIT = 0;
  localparam int ST_RATE_BIT = 1;
  localparam int ST_SKIP_BIT = 2;
  localparam int ST_PLL_BIT = 3;
  localparam int ST_DET_LSB = 4;

  localparam logic [1:0] SPEED_AUTO = 2'h0;
  localparam logic [1:0] SPEED_SD = 2'h1;
  localparam logic [1:0] SPEED_HD = 2'h2;
  localparam logic [1:0] DET_SD = 2'h1;
  localparam logic [1:0] DET_HD = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int SYNC_W = 9;
endpackage

// >>> dv/reclock_ctrl_props.sv
// checker for the reclocker control ports
`timescale 1ns/1ps
module reclock_ctrl_props
  import reclock_ctrl_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  input wire logic       pll_lock_i,
  input wire logic [1:0] rate_detect_i,
  input wire logic       pll_acquired_flag_o,
  input wire logic       rate_class_indicator_o,
  input wire logic       second_serial_output_o,
  input wire logic       crystal_drive_out_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic rate_bad;
  logic rate_not_sd;
  assign rate_bad = rate_detect_i[0] == rate_detect_i[1];
  assign rate_not_sd = rate_detect_i != DET_SD;
  // 16 cycles span the input sync plus one reference tick
  property p_lock_pll; (!pll_lock_i) [*8] ##1 (!pll_lock_i) [*8] |-> !pll_acquired_flag_o;
  endproperty
  a_lock_pll: assert property (p_lock_pll) else $error("lock without pll");
  property p_lock_rate; rate_bad [*8] ##1 rate_bad [*8] |-> !pll_acquired_flag_o;
  endproperty
  a_lock_rate: assert property (p_lock_rate) else $error("lock on bad rate");
  property p_class_sd; rate_not_sd [*8] ##1 rate_not_sd [*8] |-> !rate_class_indicator_o;
  endproperty
  a_class_sd: assert property (p_class_sd) else $error("class without sd");
  property p_class_rise; $rose(rate_class_indicator_o) |-> $past(pll_acquired_flag_o);
  endproperty
  a_class_rise: assert property (p_class_rise) else $error("class rose unlocked");
  property p_class_low; (!pll_acquired_flag_o) [*8] |-> !rate_class_indicator_o;
  endproperty
  a_class_low: assert property (p_class_low) else $error("class high unlocked");
  property p_xtal_run; $rose(crystal_drive_out_o) |-> ##[1:4] $fell(crystal_drive_out_o);
  endproperty
  a_xtal_run: assert property (p_xtal_run) else $error("reference stalled");
  property p_lock_glitch; $changed(pll_acquired_flag_o) |=> $stable(pll_acquired_flag_o);
  endproperty
  a_lock_glitch: assert property (p_lock_glitch) else $error("lock glitch");
  property p_class_glitch; $changed(rate_class_indicator_o) |=> $stable(rate_class_indicator_o);
  endproperty
  a_class_glitch: assert property (p_class_glitch) else $error("class glitch");
  c_lock: cover property ($rose(pll_acquired_flag_o));
  c_sd: cover property ($rose(rate_class_indicator_o));
  c_clk: cover property ($rose(second_serial_output_o));
endmodule // reclock_ctrl_props

bind reclock_ctrl reclock_ctrl_props u_props (
  .sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i),
  .pll_lock_i(pll_lock_i),
  .rate_detect_i(rate_detect_i),
  .pll_acquired_flag_o(pll_acquired_flag_o),
  .rate_class_indicator_o(rate_class_indicator_o),
  .second_serial_output_o(second_serial_output_o),
  .crystal_drive_out_o(crystal_drive_out_o)
);

// >>> dv/reclock_board_model.sv
// board-side model of the front end feeding the control logic
`timescale 1ns/1ps
module reclock_board_model (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       lock_req_i,
  input  wire logic       det_req_i,
  input  wire logic [1:0] rate_req_i,
  input  wire logic [3:0] data_req_i,
  output logic            pll_lock_o,
  output logic            signal_detect_o,
  output logic [1:0]      rate_detect_o,
  output logic [3:0]      serial_o,
  output logic            rec_clk_o
);
  logic [2:0] div_r;
  // the recovered clock stands still while nothing is locked
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) div_r <= 3'h0;
    else if (lock_req_i && det_req_i) div_r <= div_r + 3'h1;
  end
  assign rec_clk_o = div_r[2];
  assign pll_lock_o = lock_req_i;
  assign signal_detect_o = det_req_i;
  // without data the detector reports no rate, not the last one
  assign rate_detect_o = det_req_i ? rate_req_i : 2'h0;
  assign serial_o = data_req_i;
endmodule // reclock_board_model

// >>> dv/reclock_ctrl_tb.sv
// self-checking bench for the reclocker control logic
`timescale 1ns/1ps
module reclock_ctrl_tb import reclock_ctrl_pkg::*;;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rate_detect_i, rate_req = 2'h0;
  logic [3:0]  s_axi_wstrb = 4'hf, serial_input_i, data_req = 4'h0;
  logic        recovered_clk_i, pll_lock_i, signal_detect_i, lock_req = 1'b0, det_req = 1'b0;
  logic        primary_serial_output_o, second_serial_output_o, pll_acquired_flag_o;
  logic        rate_class_indicator_o, crystal_drive_out_o;
  int          num_errors = 0, check_count = 0, cycles = 0;

  // the 8 ns bench clock stands in for the 125 MHz system clock that the divider counts
  always #4 sys_clk_i = ~sys_clk_i;

  reclock_ctrl i_dut (.*);
  reclock_board_model i_board (
    .sys_clk_i, .reset_n_i, .lock_req_i(lock_req), .det_req_i(det_req), .rate_req_i(rate_req),
    .data_req_i(data_req), .pll_lock_o(pll_lock_i), .signal_detect_o(signal_detect_i),
    .rate_detect_o(rate_detect_i), .serial_o(serial_input_i), .rec_clk_o(recovered_clk_i));

  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // covers input sync, one tick for the lock flag and one more for the class
  task automatic settle;
    repeat (40) @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic ctl(input logic [7:0] v);
    logic [1:0] r;
    wr(CTRL_OFFSET, {24'h00_0000, v}, r);
    chk("wr_okay", 32'(r), 32'(RESP_OKAY));
    settle();
  endtask

  task automatic edges(input logic sel, output int n);
    logic p;
    n = 0;
    p = sel ? crystal_drive_out_o : second_serial_output_o;
    repeat (32) begin
      @(posedge sys_clk_i);
      if ((sel ? crystal_drive_out_o : second_serial_output_o) !== p) n++;
      p = sel ? crystal_drive_out_o : second_serial_output_o;
    end
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(CTRL_OFFSET, d, r);
    chk("ctrl_reset", d, 32'h0000_0009);
    rd(32'h0000_0040, d, r);
    chk("rd_unmapped", 32'(r), 32'(RESP_SLVERR));
    chk("rd_unmapped_data", d, 32'h0000_0000);
    wr(32'h0000_0040, 32'h0000_00ff, r);
    chk("wr_unmapped", 32'(r), 32'(RESP_SLVERR));
    rd(CTRL_OFFSET, d, r);
    chk("ctrl_kept", d, 32'h0000_0009);
  endtask

  task automatic t_lock;
    logic [31:0] d;
    logic [1:0] r;
    data_req <= 4'hf;
    lock_req <= 1'b1;
    det_req <= 1'b1;
    rate_req <= DET_SD;
    settle();
    chk("lock", pll_acquired_flag_o, 1'b1);
    chk("class_sd", rate_class_indicator_o, 1'b1);
    rd(STATUS_OFFSET, d, r);
    chk("retimed", d[ST_SKIP_BIT], 1'b0);
    chk("st_lock", d[ST_LOCK_BIT], 1'b1);
    chk("st_det", 32'(d[ST_DET_LSB +: 2]), 32'(DET_SD));
    rate_req <= DET_HD;
    settle();
    chk("class_hd", rate_class_indicator_o, 1'b0);
    rate_req <= 2'h3;
    settle();
    chk("lock_bad_rate", pll_acquired_flag_o, 1'b0);
    rate_req <= DET_SD;
    det_req <= 1'b0;
    settle();
    chk("lock_no_data", pll_acquired_flag_o, 1'b0);
    chk("class_unlocked", rate_class_indicator_o, 1'b0);
    rd(STATUS_OFFSET, d, r);
    chk("skip_unlocked", d[ST_SKIP_BIT], 1'b1);
    chk("skip_pass", primary_serial_output_o, 1'b1);
    // board ties the silence control to the lock flag
    ctl({7'h04, pll_acquired_flag_o});
    chk("tied_mute", primary_serial_output_o, 1'b0);
    ctl(8'h09);
    det_req <= 1'b1;
    settle();
    lock_req <= 1'b0;
    settle();
    chk("lock_no_pll", pll_acquired_flag_o, 1'b0);
    lock_req <= 1'b1;
    settle();
  endtask

  task automatic t_force;
    int n;
    for (int k = 0; k < 4; k++) begin
      data_req <= 4'h1 << k;
      ctl({2'(k), 6'h0b});
      chk("sel_hi", primary_serial_output_o, 1'b1);
      data_req <= ~(4'h1 << k);
      settle();
      chk("sel_lo", primary_serial_output_o, 1'b0);
    end
    chk("force_lock", pll_acquired_flag_o, 1'b0);
    chk("force_class", rate_class_indicator_o, 1'b0);
    data_req <= 4'hf;
    ctl(8'h0a);
    chk("mute_pri", primary_serial_output_o, 1'b0);
    chk("mute_sec", second_serial_output_o, 1'b0);
    ctl(8'h0b);
    chk("sec_data", second_serial_output_o, 1'b1);
    ctl(8'h0f);
    chk("sec_clk_skip", second_serial_output_o, 1'b0);
    ctl(8'h0d);
    chk("auto_lock", pll_acquired_flag_o, 1'b1);
    chk("retimed_pri", primary_serial_output_o, 1'b1);
    edges(1'b0, n);
    chk("sec_clk_runs", n > 0, 1'b1);
  endtask

  task automatic t_speed;
    logic [1:0] sp [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h3};
    logic [1:0] rt [6] = '{DET_HD, DET_SD, DET_SD, DET_HD, DET_HD, DET_SD};
    logic [5:0] ex = 6'h3a;
    for (int i = 0; i < 6; i++) begin
      rate_req <= rt[i];
      ctl({2'h0, sp[i], 4'h9});
      chk("speed_lock", pll_acquired_flag_o, ex[i]);
    end
  endtask

  task automatic t_enable;
    int n;
    ctl(8'h01);
    chk("off_lock", pll_acquired_flag_o, 1'b0);
    chk("off_pri", primary_serial_output_o, 1'b0);
    edges(1'b1, n);
    chk("off_ref_runs", n > 0, 1'b1);
    ctl(8'h09);
    chk("on_lock", pll_acquired_flag_o, 1'b1);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_lock();
    t_force();
    t_speed();
    t_enable();
    report_and_stop();
  end
endmodule // reclock_ctrl_tb
